// file: twm_pkg.sv
/*
 * Shared definitions for the two-wire master receiver: register map,
 * control bit positions, status codes, bus timing and the state record.
 * Assumes a 40 MHz system clock and an APB master with 32-bit data.
 */
package twm_pkg;

    // register byte offsets
    localparam int         APB_AW        = 8;
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_DATA      = 8'h04;
    localparam logic [7:0] OFS_STATUS    = 8'h08;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h0C;
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h10;

    // serial_control_reg bit positions
    localparam int CTL_FLAG = 7;
    localparam int CTL_ACK  = 6;
    localparam int CTL_STA  = 5;
    localparam int CTL_STO  = 4;
    localparam int CTL_WCOL = 3;
    localparam int CTL_EN   = 2;
    localparam int CTL_IE   = 0;

    // bus_status_reg codes; low three bits are the prescaler field
    localparam logic [7:0] ST_START    = 8'h08;
    localparam logic [7:0] ST_RSTART   = 8'h10;
    localparam logic [7:0] ST_MT_ACK   = 8'h18;
    localparam logic [7:0] ST_MT_NACK  = 8'h20;
    localparam logic [7:0] ST_ARB      = 8'h38;
    localparam logic [7:0] ST_AR_ACK   = 8'h40;
    localparam logic [7:0] ST_AR_NACK  = 8'h48;
    localparam logic [7:0] ST_RX_ACK   = 8'h50;
    localparam logic [7:0] ST_RX_NACK  = 8'h58;
    localparam logic [7:0] ST_NONE     = 8'hF8;
    localparam logic [7:0] STATUS_MASK = 8'hF8;

    // interrupt status / mask bits
    localparam int IRQ_W     = 2;
    localparam int IRQ_EVENT = 0;
    localparam int IRQ_ARB   = 1;

    // bus timing: one quarter of a 100 kHz bit
    localparam int CLK_PERIOD_NS = 25;
    localparam int QUARTER_NS    = 2500;
    localparam int QUARTER_CYC   =
        (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TICK_W        = 16;

    // bit phases and bit counter marks
    localparam logic [1:0] PH_DRIVE  = 2'h0;
    localparam logic [1:0] PH_RISE   = 2'h1;
    localparam logic [1:0] PH_SAMPLE = 2'h2;
    localparam logic [1:0] PH_FALL   = 2'h3;
    localparam logic [3:0] BIT_ACK   = 4'h8;
    localparam logic [7:0] DATA_RST  = 8'h00;

    typedef enum logic [2:0] {
        S_IDLE,
        S_START,
        S_BIT,
        S_STOP,
        S_WAIT
    } twm_fsm_t;

    typedef struct packed {
        twm_fsm_t          fsm;
        logic [1:0]        phase;
        logic [TICK_W-1:0] tick;
        logic [3:0]        bitn;
        logic              rx;
        logic              is_read;
        logic              ack_out;
        logic              ack_in;
        logic [7:0]        shift;
        logic              own_bus;
        logic              busy;
        logic              flag;
        logic              ack_en;
        logic              sta;
        logic              sto;
        logic              wcol;
        logic              en;
        logic              ie;
        logic [7:0]        data;
        logic [7:0]        status;
        logic [IRQ_W-1:0]  irq_stat;
        logic [IRQ_W-1:0]  irq_mask;
        logic [2:0]        scl_sync;
        logic [2:0]        sda_sync;
        logic              scl_lvl;
        logic              sda_lvl;
        logic              sda_prev;
        logic              scl_oe_n;
        logic              sda_oe_n;
        logic              pready;
        logic              pslverr;
        logic [31:0]       prdata;
        logic              irq;
    } twm_state_t;

endpackage

// file: twm_master_rx.sv
/*
 * Two-wire master receiver with APB register access and one interrupt.
 * Assumes open-drain pads outside (oe_n low pulls the line low), a
 * pull-up on both lines, and an APB master on CLK_I.
 */
// Overview of operation
// RL1 - start write waits for an idle bus, then issues START
// RL2 - after START the flag sets and status shows 0x08
// RL3 - address direction bit chooses master transmit or master receive
// RL4 - software compares status with prescaler bits zero or masked
// RL5 - writing one to the flag clears it; address sent with sta/sto zero
// RL6 - after read address and its ack, flag sets with 0x38/0x40/0x48
// RL7 - received byte is in the data register when flag sets
// RL8 - software clears ack enable before last byte so NACK is returned
// RL9 - stop write sends STOP, then hardware clears the stop request
// RL10 - start write while owning the bus sends repeated START, no STOP
// RL11 - after repeated START status is 0x10 and the bus stays owned
// RL12 - in 0x10 a read address stays receive, write address goes transmit
// RL13 - in 0x08 clearing the flag sends the address and samples ack
// RL14 - in 0x38 release bus, or queue START until bus is free
// RL15 - in 0x40/0x50 next byte received, ack per ack enable
// RL16 - in 0x48 start, stop, or stop then start; stop bit then cleared
// RL17 - in 0x58 byte readable; start, stop or stop then start follows
// RL18 - while the flag is set and the bus is owned the clock line is held low
`timescale 1ns/10ps
module twm_master_rx #(
    parameter int QUARTER_CYC = twm_pkg::QUARTER_CYC
) (
    // system
    input  wire logic        CLK_I,
    input  wire logic        RST_I,
    // apb slave
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic             PREADY_O,
    output logic [31:0]      PRDATA_O,
    output logic             PSLVERR_O,
    // two-wire pins
    input  wire logic        SCL_I,
    output logic             SCL_O,
    output logic             SCL_OE_N_O,
    input  wire logic        SDA_I,
    output logic             SDA_O,
    output logic             SDA_OE_N_O,
    // interrupt
    output logic             IRQ_O
);

    localparam twm_pkg::twm_state_t ST_RESET = '{
        fsm:      twm_pkg::S_IDLE,
        status:   twm_pkg::ST_NONE,
        data:     twm_pkg::DATA_RST,
        scl_sync: 3'h7,
        sda_sync: 3'h7,
        scl_lvl:  1'h1,
        sda_lvl:  1'h1,
        sda_prev: 1'h1,
        scl_oe_n: 1'h1,
        sda_oe_n: 1'h1,
        default:  '0
    };

    localparam int IRQ_W_L = twm_pkg::IRQ_W;

    twm_pkg::twm_state_t s;
    twm_pkg::twm_state_t n;

    logic step;
    logic stretch;
    logic acc_done;
    logic fin_start;
    logic fin_stop;
    logic fin_bit;
    logic arb_lost;
    logic wr_ctrl;
    logic dispatch;

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == twm_pkg::OFS_CTRL) || (a == twm_pkg::OFS_DATA) ||
                    (a == twm_pkg::OFS_STATUS) ||
                    (a == twm_pkg::OFS_IRQ_STAT) ||
                    (a == twm_pkg::OFS_IRQ_MASK);
    endfunction

    assign step     = (s.tick == twm_pkg::TICK_W'(QUARTER_CYC - 1));
    assign stretch  = (s.phase == twm_pkg::PH_SAMPLE) && !s.scl_lvl;
    assign acc_done = PSEL_I && PENABLE_I && s.pready;
    assign wr_ctrl  = acc_done && PWRITE_I && (PADDR_I == twm_pkg::OFS_CTRL);
    assign fin_start = (s.fsm == twm_pkg::S_START) &&
                       (s.phase == twm_pkg::PH_FALL) && step;
    assign fin_stop  = (s.fsm == twm_pkg::S_STOP) &&
                       (s.phase == twm_pkg::PH_FALL) && step;
    assign fin_bit   = (s.fsm == twm_pkg::S_BIT) &&
                       (s.phase == twm_pkg::PH_FALL) && step &&
                       (s.bitn == twm_pkg::BIT_ACK);
    // a released data line read low while we send one means another master
    assign arb_lost  = (s.fsm == twm_pkg::S_BIT) && s.en &&
                       (s.phase == twm_pkg::PH_SAMPLE) && step &&
                       !stretch && s.sda_oe_n && !s.sda_lvl &&
                       (s.rx ? (s.bitn == twm_pkg::BIT_ACK)
                             : (s.bitn != twm_pkg::BIT_ACK));
    assign dispatch  = (s.fsm == twm_pkg::S_WAIT) && !s.flag && s.en;

    always_comb begin
        logic [IRQ_W_L-1:0] irq_set;
        logic [IRQ_W_L-1:0] irq_clr;
        logic               start_seen;
        logic               stop_seen;
        irq_set = '0;
        irq_clr = '0;
        start_seen = 1'h0;
        stop_seen  = 1'h0;
        n = s;

        // pin inputs: three stages, level moves when the last two agree
        n.scl_sync = {s.scl_sync[1:0], SCL_I};
        n.sda_sync = {s.sda_sync[1:0], SDA_I};
        if (s.scl_sync[1] == s.scl_sync[2]) begin
            n.scl_lvl = s.scl_sync[2];
        end
        if (s.sda_sync[1] == s.sda_sync[2]) begin
            n.sda_lvl = s.sda_sync[2];
        end
        n.sda_prev = s.sda_lvl;
        start_seen = s.scl_lvl && s.sda_prev && !s.sda_lvl;
        stop_seen  = s.scl_lvl && !s.sda_prev && s.sda_lvl;
        if (start_seen) begin
            n.busy = 1'h1;
        end else if (stop_seen) begin
            n.busy = 1'h0;
        end

        // apb: answer one cycle into the access phase, commit on pready
        n.pready = 1'h0;
        if (PSEL_I && PENABLE_I && !s.pready) begin
            n.pready  = 1'h1;
            n.pslverr = !is_mapped(PADDR_I);
            unique case (PADDR_I)
                twm_pkg::OFS_CTRL:     n.prdata = {24'h0, s.flag, s.ack_en,
                    s.sta, s.sto, s.wcol, s.en, 1'h0, s.ie};
                twm_pkg::OFS_DATA:     n.prdata = {24'h0, s.data};
                // prescaler field always reads zero  (see RL4)
                twm_pkg::OFS_STATUS:   n.prdata = {24'h0,
                    s.status & twm_pkg::STATUS_MASK};
                twm_pkg::OFS_IRQ_STAT: n.prdata = {30'h0, s.irq_stat};
                twm_pkg::OFS_IRQ_MASK: n.prdata = {30'h0, s.irq_mask};
                default:               n.prdata = 32'h0;
            endcase
        end
        if (acc_done && PWRITE_I) begin
            unique case (PADDR_I)
                twm_pkg::OFS_CTRL: begin
                    if (PWDATA_I[twm_pkg::CTL_FLAG]) begin
                        n.flag = 1'h0;  // see RL5
                    end
                    n.ack_en = PWDATA_I[twm_pkg::CTL_ACK];  // see RL8
                    n.sta    = PWDATA_I[twm_pkg::CTL_STA];  // see RL1
                    n.sto    = PWDATA_I[twm_pkg::CTL_STO];
                    n.en     = PWDATA_I[twm_pkg::CTL_EN];
                    n.ie     = PWDATA_I[twm_pkg::CTL_IE];
                end
                twm_pkg::OFS_DATA: begin
                    // the shifter owns the byte while the flag is low
                    if (s.flag) begin
                        n.data = PWDATA_I[7:0];
                        n.wcol = 1'h0;
                    end else begin
                        n.wcol = 1'h1;
                    end
                end
                twm_pkg::OFS_IRQ_MASK: n.irq_mask = PWDATA_I[IRQ_W_L-1:0];
                default: ;
            endcase
        end
        if (acc_done && !PWRITE_I && (PADDR_I == twm_pkg::OFS_IRQ_STAT)) begin
            irq_clr = s.irq_stat;
        end

        // quarter-bit timer, held off while a slave stretches the clock
        if (s.fsm == twm_pkg::S_START || s.fsm == twm_pkg::S_STOP ||
            s.fsm == twm_pkg::S_BIT) begin
            if (stretch || step) begin
                n.tick = '0;
            end else begin
                n.tick = s.tick + 1'h1;
            end
            if (step && !stretch) begin
                n.phase = s.phase + 2'h1;
            end
        end

        unique case (s.fsm)
            twm_pkg::S_IDLE: begin
                // wait for a free bus  (see RL1, RL14)
                if (s.en && s.sta && !s.flag && !s.busy) begin
                    n.fsm   = twm_pkg::S_START;
                    n.phase = twm_pkg::PH_DRIVE;
                    n.tick  = '0;
                    n.busy  = 1'h1;
                end
            end
            twm_pkg::S_START: begin
                if (fin_start) begin
                    // repeated start keeps the bus  (see RL2, RL10, RL11)
                    n.status  = s.own_bus ? twm_pkg::ST_RSTART
                                          : twm_pkg::ST_START;
                    n.own_bus = 1'h1;
                    n.flag    = 1'h1;
                    n.fsm     = twm_pkg::S_WAIT;
                    irq_set[twm_pkg::IRQ_EVENT] = 1'h1;
                end
            end
            twm_pkg::S_STOP: begin
                if (fin_stop) begin
                    // a pending start then waits in idle  (see RL9, RL16)
                    n.sto     = 1'h0;
                    n.own_bus = 1'h0;
                    n.status  = twm_pkg::ST_NONE;
                    n.fsm     = twm_pkg::S_IDLE;
                end
            end
            twm_pkg::S_BIT: begin
                if (arb_lost) begin
                    // see RL14
                    n.status  = twm_pkg::ST_ARB;
                    n.flag    = 1'h1;
                    n.own_bus = 1'h0;
                    n.fsm     = twm_pkg::S_WAIT;
                    irq_set[twm_pkg::IRQ_EVENT] = 1'h1;
                    irq_set[twm_pkg::IRQ_ARB]   = 1'h1;
                end else if (s.phase == twm_pkg::PH_SAMPLE && step &&
                             !stretch) begin
                    if (s.bitn == twm_pkg::BIT_ACK) begin
                        n.ack_in = !s.sda_lvl;  // see RL13
                    end else if (s.rx) begin
                        n.shift = {s.shift[6:0], s.sda_lvl};
                    end
                end else if (s.phase == twm_pkg::PH_FALL && step) begin
                    if (s.bitn != twm_pkg::BIT_ACK) begin
                        n.bitn = s.bitn + 4'h1;
                        if (!s.rx) begin
                            n.shift = {s.shift[6:0], 1'h0};
                        end
                    end else begin
                        n.flag = 1'h1;
                        n.fsm  = twm_pkg::S_WAIT;
                        irq_set[twm_pkg::IRQ_EVENT] = 1'h1;
                        if (s.rx) begin
                            n.data   = s.shift;  // see RL7
                            n.status = s.ack_out ? twm_pkg::ST_RX_ACK
                                                 : twm_pkg::ST_RX_NACK;
                        end else if (s.is_read) begin
                            n.status = s.ack_in ? twm_pkg::ST_AR_ACK
                                                : twm_pkg::ST_AR_NACK;
                        end else begin
                            // write address hands over to transmit codes
                            n.status = s.ack_in ? twm_pkg::ST_MT_ACK
                                                : twm_pkg::ST_MT_NACK;
                        end
                    end
                end
            end
            twm_pkg::S_WAIT: begin
                if (dispatch) begin
                    n.tick  = '0;
                    n.phase = twm_pkg::PH_DRIVE;
                    n.bitn  = '0;
                    unique case (s.status)
                        twm_pkg::ST_START, twm_pkg::ST_RSTART: begin
                            // see RL3, RL12, RL13
                            n.fsm     = twm_pkg::S_BIT;
                            n.rx      = 1'h0;
                            n.shift   = s.data;
                            n.is_read = s.data[0];
                        end
                        twm_pkg::ST_AR_ACK, twm_pkg::ST_RX_ACK: begin
                            // see RL15
                            n.fsm     = twm_pkg::S_BIT;
                            n.rx      = 1'h1;
                            n.shift   = '0;
                            n.ack_out = s.ack_en;
                        end
                        twm_pkg::ST_ARB, twm_pkg::ST_NONE: begin
                            n.fsm = twm_pkg::S_IDLE;  // see RL14
                        end
                        default: begin
                            // see RL16, RL17
                            if (s.sto) begin
                                n.fsm = twm_pkg::S_STOP;
                            end else if (s.sta) begin
                                n.fsm = twm_pkg::S_START;
                            end
                        end
                    endcase
                end
            end
            default: n.fsm = twm_pkg::S_IDLE;
        endcase

        // disabling the unit drops the bus at once
        if (!s.en) begin
            n.fsm     = twm_pkg::S_IDLE;
            n.own_bus = 1'h0;
            n.tick    = '0;
        end

        // pin drive from the next state; oe_n low pulls the line low
        unique case (n.fsm)
            twm_pkg::S_IDLE: begin
                n.scl_oe_n = 1'h1;
                n.sda_oe_n = 1'h1;
            end
            twm_pkg::S_WAIT: begin
                n.scl_oe_n = !n.own_bus;  // see RL18
                if (!n.own_bus) begin
                    n.sda_oe_n = 1'h1;
                end
            end
            twm_pkg::S_START: begin
                unique case (n.phase)
                    twm_pkg::PH_DRIVE:  n.sda_oe_n = 1'h1;
                    twm_pkg::PH_RISE:   n.scl_oe_n = 1'h1;
                    twm_pkg::PH_SAMPLE: n.sda_oe_n = 1'h0;
                    twm_pkg::PH_FALL:   n.scl_oe_n = 1'h0;
                endcase
            end
            twm_pkg::S_STOP: begin
                unique case (n.phase)
                    twm_pkg::PH_DRIVE:  n.sda_oe_n = 1'h0;
                    twm_pkg::PH_RISE:   n.scl_oe_n = 1'h1;
                    twm_pkg::PH_SAMPLE: n.sda_oe_n = 1'h1;
                    twm_pkg::PH_FALL:   n.sda_oe_n = 1'h1;
                endcase
            end
            twm_pkg::S_BIT: begin
                unique case (n.phase)
                    twm_pkg::PH_DRIVE: begin
                        n.scl_oe_n = 1'h0;
                        if (n.bitn == twm_pkg::BIT_ACK) begin
                            n.sda_oe_n = n.rx ? !n.ack_out : 1'h1;
                        end else begin
                            n.sda_oe_n = n.rx ? 1'h1 : n.shift[7];
                        end
                    end
                    twm_pkg::PH_RISE:   n.scl_oe_n = 1'h1;
                    twm_pkg::PH_SAMPLE: n.scl_oe_n = 1'h1;
                    twm_pkg::PH_FALL:   n.scl_oe_n = 1'h0;
                endcase
            end
            default: ;
        endcase

        // hardware set wins over a read-clear in the same cycle
        n.irq_stat = (s.irq_stat & ~irq_clr) | irq_set;
        n.irq      = |(n.irq_stat & n.irq_mask);
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            s <= ST_RESET;
        end else begin
            s <= n;
        end
    end

    assign PREADY_O   = s.pready;
    assign PRDATA_O   = s.prdata;
    assign PSLVERR_O  = s.pslverr;
    assign SCL_OE_N_O = s.scl_oe_n;
    assign SDA_OE_N_O = s.sda_oe_n;
    assign SCL_O      = 1'h0;
    assign SDA_O      = 1'h0;
    assign IRQ_O      = s.irq;

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    a_start_code: assert property (fin_start && s.en |=> s.flag && // see RL2
        (s.status == twm_pkg::ST_START || s.status == twm_pkg::ST_RSTART))
        else $error("start did not report its status");
    a_rstart_keep: assert property (fin_start && s.en && s.own_bus // see RL11
        |=> s.status == twm_pkg::ST_RSTART && s.own_bus && !SCL_OE_N_O)
        else $error("repeated start lost the bus");
    a_addr_result: assert property (fin_bit && !s.rx && s.is_read // see RL6
        && s.en |=> s.flag && (s.status == twm_pkg::ST_AR_ACK ||
        s.status == twm_pkg::ST_AR_NACK))
        else $error("read address gave wrong status");
    a_rx_byte: assert property (fin_bit && s.rx && s.en // see RL7
        |=> s.flag && s.data == $past(s.shift))
        else $error("received byte not in data register");
    a_ack_drive: assert property (s.fsm == twm_pkg::S_BIT && s.rx && // see RL15
        s.bitn == twm_pkg::BIT_ACK && s.phase == twm_pkg::PH_SAMPLE
        |-> SDA_OE_N_O == !s.ack_out)
        else $error("ack bit driven wrongly");
    a_hold_clock: assert property (s.fsm == twm_pkg::S_WAIT && s.flag // see RL18
        && s.own_bus |-> !SCL_OE_N_O)
        else $error("clock released while flag set");
    a_stop_clear: assert property (fin_stop && s.en // see RL9
        |=> !s.sto && !s.own_bus ##1 SDA_OE_N_O && SCL_OE_N_O)
        else $error("stop request not cleared");
    a_busy_wait: assert property (s.fsm == twm_pkg::S_IDLE && s.busy // see RL1
        |=> s.fsm != twm_pkg::S_START)
        else $error("start issued on a busy bus");
    a_arb_release: assert property (arb_lost |=> // see RL14
        s.status == twm_pkg::ST_ARB && s.flag && SCL_OE_N_O && SDA_OE_N_O)
        else $error("arbitration loss not handled");
    a_flag_clear: assert property (wr_ctrl && PWDATA_I[twm_pkg::CTL_FLAG] // see RL5
        && s.fsm == twm_pkg::S_WAIT |=> !s.flag)
        else $error("flag not cleared by write of one");
    a_addr_send: assert property (dispatch && (s.status == // see RL13
        twm_pkg::ST_START || s.status == twm_pkg::ST_RSTART)
        |=> s.fsm == twm_pkg::S_BIT && !s.rx && s.shift == $past(s.data))
        else $error("address not loaded for sending");
    a_nack_stop: assert property (dispatch && s.sto && (s.status == // see RL16
        twm_pkg::ST_AR_NACK || s.status == twm_pkg::ST_RX_NACK)
        |=> s.fsm == twm_pkg::S_STOP)
        else $error("stop not sent after nack");

endmodule

// file: twm_slave_tx.sv
/* slave transmitter model: acks its own read address, sends bytes.
   assumes pull-ups; released bits read high, no clock stretching. */
`timescale 1ns/10ps
module twm_slave_tx #(parameter logic [6:0] ADDR = 7'h50) (
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      sda_oe_n_o = 1'b1
);
    int         cnt = 0;
    logic       adr = 1'b0;
    logic       act = 1'b0;
    logic [7:0] sh  = 8'h00;
    logic [7:0] tx  = 8'hC3;
    always @(negedge sda_i) if (scl_i) begin
        cnt = 0;
        adr = 1'b1;
    end
    always @(posedge scl_i) begin
        if (cnt < 8) sh = {sh[6:0], sda_i};
        else if (!adr) begin
            act = act & !sda_i; // a nack ends the read
            tx  = tx + 8'h11;
        end
        cnt = cnt + 1;
    end
    always @(negedge scl_i) begin
        if (cnt == 8 && adr) act = (sh == {ADDR, 1'b1});
        if (cnt == 9) begin
            cnt = 0;
            adr = 1'b0;
        end
        if (adr) sda_oe_n_o <= !(cnt == 8 && act);
        else sda_oe_n_o <= !(act && cnt < 8 && !tx[7 - cnt]);
    end
endmodule

// file: twm_master_rx_tb.sv
/* bench: apb registers, a read with ack and nack, repeated start, stop
   and a masked event. assumes the slave model and pull-ups. */
`timescale 1ns/10ps
module twm_master_rx_tb;
    logic             CLK_I = 1'b0;
    logic             RST_I = 1'b1;
    logic             PSEL_I = 1'b0;
    logic             PENABLE_I = 1'b0;
    logic             PWRITE_I = 1'b0;
    logic [7:0]       PADDR_I = 8'h00;
    logic [31:0]      PWDATA_I = 32'h0;
    wire logic        PREADY_O, PSLVERR_O, SCL_OE_N_O, SDA_OE_N_O, IRQ_O;
    wire logic [31:0] PRDATA_O;
    wire logic        slv_oe_n;
    wire logic        scl = SCL_OE_N_O;
    logic             rival_n = 1'b1;
    wire logic        sda = SDA_OE_N_O & slv_oe_n & rival_n;
    int               num_errors = 0;
    int               checks_done = 0;
    int               cyc = 0;
    logic             err;
    logic [31:0]      q;
    always #12.5 CLK_I = ~CLK_I;
    twm_master_rx #(.QUARTER_CYC(4)) uut (.CLK_I(CLK_I), .RST_I(RST_I),
        .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
        .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PREADY_O(PREADY_O),
        .PRDATA_O(PRDATA_O), .PSLVERR_O(PSLVERR_O), .SCL_I(scl),
        .SCL_O(), .SCL_OE_N_O(SCL_OE_N_O), .SDA_I(sda), .SDA_O(),
        .SDA_OE_N_O(SDA_OE_N_O), .IRQ_O(IRQ_O));
    twm_slave_tx slave (.scl_i(scl), .sda_i(sda), .sda_oe_n_o(slv_oe_n));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge CLK_I);
        PSEL_I   <= 1'b1;
        PWRITE_I <= w;
        PADDR_I  <= a;
        PWDATA_I <= d;
        @(posedge CLK_I);
        PENABLE_I <= 1'b1;
        do @(posedge CLK_I); while (PREADY_O !== 1'b1);
        q   = PRDATA_O;
        err = PSLVERR_O;
        PSEL_I    <= 1'b0;
        PENABLE_I <= 1'b0;
    endtask
    // write control, wait for the event, check status, clear the event
    task automatic step(input logic [7:0] c, input logic [7:0] st);
        apb(1'b1, twm_pkg::OFS_CTRL, {24'h0, c});
        while (IRQ_O !== 1'b1) @(posedge CLK_I);
        chk(32'(SCL_OE_N_O), 32'h0);
        apb(1'b0, twm_pkg::OFS_STATUS, 32'h0);
        chk(q, {24'h0, st});
        apb(1'b0, twm_pkg::OFS_IRQ_STAT, 32'h0);
    endtask
    task automatic t_read;
        apb(1'b1, twm_pkg::OFS_IRQ_MASK, 32'h1);
        step(8'hA4, 8'h08);
        apb(1'b1, twm_pkg::OFS_DATA, 32'hA1);
        step(8'hC4, 8'h40);
        step(8'hC4, 8'h50);
        apb(1'b0, twm_pkg::OFS_DATA, 32'h0);
        chk(q, 32'hC3);
        step(8'h84, 8'h58);
        apb(1'b0, twm_pkg::OFS_DATA, 32'h0);
        chk(q, 32'hD4);
        step(8'hA4, 8'h10);
        apb(1'b1, twm_pkg::OFS_DATA, 32'hA0);
        step(8'h84, 8'h20);
        step(8'hA4, 8'h10);
        apb(1'b1, twm_pkg::OFS_DATA, 32'hA3);
        step(8'h84, 8'h48);
        apb(1'b1, twm_pkg::OFS_CTRL, 32'h94);
        repeat (40) begin
            apb(1'b0, twm_pkg::OFS_CTRL, 32'h0);
            if (q[4] === 1'b0) break;
        end
        chk(q & 32'hB4, 32'h04);
    endtask
    // event still recorded while masked, but no interrupt
    task automatic t_mask;
        apb(1'b0, 8'h20, 32'h0);
        chk(32'(err), 32'h1);
        apb(1'b1, twm_pkg::OFS_IRQ_MASK, 32'h0);
        apb(1'b1, twm_pkg::OFS_CTRL, 32'hA4);
        repeat (40) begin
            apb(1'b0, twm_pkg::OFS_IRQ_STAT, 32'h0);
            if (q[0] === 1'b1) break;
        end
        chk(q, 32'h1);
        chk(32'(IRQ_O), 32'h0);
    endtask
    // a rival master holds the data line low under our first address bit
    task automatic t_arb;
        rival_n <= 1'b0;
        apb(1'b1, twm_pkg::OFS_CTRL, 32'h84);
        repeat (40) begin
            apb(1'b0, twm_pkg::OFS_IRQ_STAT, 32'h0);
            if (q[1] === 1'b1) break;
        end
        chk(q, 32'h3);
        rival_n <= 1'b1;
        apb(1'b0, twm_pkg::OFS_STATUS, 32'h0);
        chk(q, 32'h38);
        chk(32'(SCL_OE_N_O & SDA_OE_N_O), 32'h1);
        apb(1'b1, twm_pkg::OFS_CTRL, 32'h84);
    endtask
    task automatic report_and_stop;
        if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge CLK_I);
        RST_I <= 1'b0;
        t_read();
        t_mask();
        t_arb();
        report_and_stop();
    end
    always @(posedge CLK_I) if (++cyc == 20000) begin
        num_errors++;
        report_and_stop();
    end
endmodule
